// file: rtl/lsc_map.vh
// Register map, field positions and reset values of the strobe current block
`ifndef LSC_MAP_VH
`define LSC_MAP_VH
`define LSC_ADDR_W       4
`define LSC_OFF_CODE0    4'h0
`define LSC_OFF_CODE1    4'h1
`define LSC_OFF_CODE2    4'h2
`define LSC_OFF_DEAD     4'h3
`define LSC_OFF_SWCTL    4'h4
`define LSC_OFF_LIMIT    4'h5
`define LSC_OFF_STATUS   4'h6
`define LSC_CODE_W       10
`define LSC_CODE_RST     10'h029
`define LSC_DEAD_W       8
`define LSC_DEAD_RST     8'h04
`define LSC_SWCTL_RST    9'h111
`define LSC_LIM_LVL_LSB  0
`define LSC_LIM_EN_LSB   4
`define LSC_LIM_RST      7'h10
`define LSC_SEL_RED      2'h0
`define LSC_SEL_GREEN    2'h1
`define LSC_SEL_BLUE     2'h2
`define LSC_SEL_OFF      2'h3
`endif

// file: rtl/lsc_strobe_ctrl.v
// Colour strobe decoder with break-before-make and per-colour current codes
`include "lsc_map.vh"

// Block overview
// Colour select pins and rail flags arrive from outside the clock domain
// and pass two flip-flops before the sequencer reads them.
// Software sets three current codes, a dead time, a switch pattern per
// colour and a transient limit over a small register port.
// Apart from rail loss, the sequencer clears switches only on the first step of a change,
// so a make can never land in the same cycle as a break.
// Switches that both patterns share are kept closed through the gap,
// which avoids a needless current dip on a shared cathode.
// The current code output follows the index latched at the break, so the
// regulator already aims at the new colour when the new switch closes.
// Limit flag marks a closure of a switch whose enable bit is set; the
// analog limiter itself lives outside this block.
// Limitation: a selection change during the dead time waits for it to end.

// How it works
// - Two-bit colour select picks switch pattern and that colour's current code.
// - Decoder and driver stay disabled until all three supply rails are up.
// - On a selection change, open leaving switches before closing new ones.
// - Dead time between break and make comes from the dead time register.
// - Switches closed now and kept closed stay closed during the dead time.
// - Three independent 10-bit current codes, one per colour select code.
// - Code maps linearly to current; full scale is maximum trimmed current.
// - Regulation target follows the code of the newly selected colour.
// - Transition current is capped by the 4-bit transient limit level.
// - Limiting applies only to switches whose enable bit is set.
module lsc_strobe_ctrl #(
    parameter CODE_W = `LSC_CODE_W,
    parameter DEAD_W = `LSC_DEAD_W
) (
    input  wire              sys_clk,
    input  wire              reset,
    input  wire [1:0]        colourSel,
    input  wire [2:0]        railsUp,
    input  wire [3:0]        avs_address,
    input  wire              avs_read,
    input  wire              avs_write,
    input  wire [31:0]       avs_writedata,
    output reg  [31:0]       avs_readdata,
    output wire              avs_waitrequest,
    output wire [2:0]        switchOn,
    output wire [CODE_W-1:0] currentCode,
    output wire              limitActive,
    output wire [3:0]        limitLevel,
    output wire              driverEnable
);

    localparam ST_OFF   = 3'b001;
    localparam ST_STEADY= 3'b010;
    localparam ST_DEAD  = 3'b100;

    // Both pin groups are plain levels from another domain.
    // Each bit is synchronised on its own; a two-bit select may show a
    // wrong code for one cycle, which the sequencer in the steady state latches as its goal.
    // Reset holds the select at all-off so no false change follows reset.

    // Pin synchronisers: first stage only feeds the second
    reg [1:0] selMeta_ff;
    reg [1:0] selSync_ff;
    reg [2:0] railMeta_ff;
    reg [2:0] railSync_ff;
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            selMeta_ff  <= `LSC_SEL_OFF;
            selSync_ff  <= `LSC_SEL_OFF;
            railMeta_ff <= 3'h0;
            railSync_ff <= 3'h0;
        end
        else
        begin
            selMeta_ff  <= colourSel;
            selSync_ff  <= selMeta_ff;
            railMeta_ff <= railsUp;
            railSync_ff <= railMeta_ff;
        end
    end

    // Register file held in flip-flops, one word per index.
    // Codes sit in the low bits and read back with upper bits zero.
    // Unmapped indexes read zero and ignore writes.
    // The status word is read only.

    // Software registers
    reg [CODE_W-1:0] code0_ff;
    reg [CODE_W-1:0] code1_ff;
    reg [CODE_W-1:0] code2_ff;
    reg [DEAD_W-1:0] dead_ff;
    reg [8:0]        swCtl_ff;
    reg [6:0]        limit_ff;
    reg              ack_ff;
    wire             access = (avs_read | avs_write) & ~ack_ff;

    // Waitrequest is high in the first cycle of every access and low in
    // the second, when the acknowledge flop is set.
    // The master must hold its request until it sees it low.
    // Back to back requests pay the wait cycle again.

    // One wait cycle per access keeps read data registered
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;

    always @(posedge sys_clk)
    begin
        if (reset)
            ack_ff <= 1'b0;
        else
            ack_ff <= access;
    end

    // Register writes take effect on the acknowledging edge
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            code0_ff <= `LSC_CODE_RST;
            code1_ff <= `LSC_CODE_RST;
            code2_ff <= `LSC_CODE_RST;
            dead_ff  <= `LSC_DEAD_RST;
            swCtl_ff <= `LSC_SWCTL_RST;
            limit_ff <= `LSC_LIM_RST;
        end
        else if (avs_write & ack_ff)
        begin
            case (avs_address)
                `LSC_OFF_CODE0: code0_ff <= avs_writedata[CODE_W-1:0];
                `LSC_OFF_CODE1: code1_ff <= avs_writedata[CODE_W-1:0];
                `LSC_OFF_CODE2: code2_ff <= avs_writedata[CODE_W-1:0];
                `LSC_OFF_DEAD:  dead_ff  <= avs_writedata[DEAD_W-1:0];
                `LSC_OFF_SWCTL: swCtl_ff <= avs_writedata[8:0];
                `LSC_OFF_LIMIT: limit_ff <= avs_writedata[6:0];
                default:        code0_ff <= code0_ff;
            endcase
        end
    end

    // Decode selection into target pattern, kept off while rails are down
    reg  [2:0]       target;
    reg  [1:0]       tgtIdx;
    wire             railsOk = &railSync_ff;
    always @*
    begin
        target = 3'h0;
        tgtIdx = 2'h0;
        case (selSync_ff)
            `LSC_SEL_RED:
            begin
                target = swCtl_ff[2:0];
                tgtIdx = 2'h0;
            end
            `LSC_SEL_GREEN:
            begin
                target = swCtl_ff[5:3];
                tgtIdx = 2'h1;
            end
            `LSC_SEL_BLUE:
            begin
                target = swCtl_ff[8:6];
                tgtIdx = 2'h2;
            end
            default:
            begin
                target = 3'h0;
                tgtIdx = 2'h0;
            end
        endcase
        if (!railsOk)
            target = 3'h0;
    end

    // Sequencer timing for a change seen in the steady state:
    // first edge cuts the switches to those both patterns share and
    // latches the goal, the index and the dead time count;
    // the count then runs down to zero, one sys_clk cycle per step;
    // the edge after zero closes the goal pattern.
    // A dead time of D therefore gives D plus one cycles of gap.
    // Rails going down at any point force every switch open at once,
    // since no sequencing matters once the supply is gone.

    // Break-before-make sequencer
    reg [2:0]        state_ff;
    reg [2:0]        sw_ff;
    reg [2:0]        goal_ff;
    reg [1:0]        idx_ff;
    reg [DEAD_W-1:0] cnt_ff;
    reg              lim_ff;
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_ff <= ST_OFF;
            sw_ff    <= 3'h0;
            goal_ff  <= 3'h0;
            idx_ff   <= 2'h0;
            cnt_ff   <= {DEAD_W{1'b0}};
            lim_ff   <= 1'b0;
        end
        else
        begin
            case (state_ff)
                ST_OFF:
                begin
                    sw_ff  <= 3'h0;
                    lim_ff <= 1'b0;
                    if (railsOk)
                        state_ff <= ST_STEADY;
                end
                ST_STEADY:
                begin
                    if (!railsOk)
                    begin
                        sw_ff    <= 3'h0;
                        state_ff <= ST_OFF;
                    end
                    else if (target != sw_ff)
                    begin
                        sw_ff    <= sw_ff & target;
                        goal_ff  <= target;
                        idx_ff   <= tgtIdx;
                        cnt_ff   <= dead_ff;
                        state_ff <= ST_DEAD;
                    end
                    else
                        lim_ff <= 1'b0;
                end
                ST_DEAD:
                begin
                    if (!railsOk)
                    begin
                        sw_ff    <= 3'h0;
                        state_ff <= ST_OFF;
                    end
                    else if (cnt_ff == {DEAD_W{1'b0}})
                    begin
                        sw_ff    <= goal_ff;
                        lim_ff   <= |(goal_ff & ~sw_ff &
                                      limit_ff[`LSC_LIM_EN_LSB+:3]);
                        state_ff <= ST_STEADY;
                    end
                    else
                        cnt_ff <= cnt_ff - {{(DEAD_W-1){1'b0}}, 1'b1};
                end
                default: state_ff <= ST_OFF;
            endcase
        end
    end

    // Current code follows the latched index one cycle later.
    // Registered so the regulator input never glitches while the
    // index and the code registers change in the same cycle.
    // Each code passes to the output unchanged; no mapping is applied here.

    // Current code of the selected switch
    reg [CODE_W-1:0] codeOut_ff;
    always @(posedge sys_clk)
    begin
        if (reset)
            codeOut_ff <= {CODE_W{1'b0}};
        else
            case (idx_ff)
                2'h0:    codeOut_ff <= code0_ff;
                2'h1:    codeOut_ff <= code1_ff;
                default: codeOut_ff <= code2_ff;
            endcase
    end

    // Outputs straight from flops, except the enable decoded from state.
    // The enable is low only in the off state, where all switches
    // are held open as well.
    assign switchOn     = sw_ff;
    assign currentCode  = codeOut_ff;
    assign limitActive  = lim_ff;
    assign limitLevel   = limit_ff[`LSC_LIM_LVL_LSB+:4];
    assign driverEnable = (state_ff != ST_OFF);

    // Read data is loaded in the wait cycle and stands from the
    // acknowledging edge until the next read.
    // Status layout: switches in the low three bits, driver enable
    // at bit five, selected index above it, limit flag at bit eight.

    // Registered read data
    always @(posedge sys_clk)
    begin
        if (reset)
            avs_readdata <= 32'h00000000;
        else if (access & avs_read)
            case (avs_address)
                `LSC_OFF_CODE0:  avs_readdata <= {22'h0, code0_ff};
                `LSC_OFF_CODE1:  avs_readdata <= {22'h0, code1_ff};
                `LSC_OFF_CODE2:  avs_readdata <= {22'h0, code2_ff};
                `LSC_OFF_DEAD:   avs_readdata <= {24'h0, dead_ff};
                `LSC_OFF_SWCTL:  avs_readdata <= {23'h0, swCtl_ff};
                `LSC_OFF_LIMIT:  avs_readdata <= {25'h0, limit_ff};
                `LSC_OFF_STATUS: avs_readdata <= {23'h0, lim_ff, idx_ff,
                                                  driverEnable, 2'h0, sw_ff};
                default:         avs_readdata <= 32'h00000000;
            endcase
    end

endmodule // lsc_strobe_ctrl

// file: verif/lsc_colour_src.sv
// Display controller model driving the colour select pins
module lsc_colour_src (
    input  wire logic       sys_clk,
    input  wire logic [1:0] want,
    output logic      [1:0] colourSel
);
    timeunit 1ns;
    timeprecision 1ps;
    // Start in the all-off code
    initial colourSel = 2'h3;
    // Pins change only just after an edge
    always @(posedge sys_clk)
        colourSel <= want;
endmodule // lsc_colour_src

// file: verif/lsc_strobe_ctrl_asserts.sv
// Port assertions for the strobe controller
module lsc_strobe_ctrl_asserts (
    input wire       sys_clk,
    input wire       reset,
    input wire [1:0] colourSel,
    input wire [2:0] railsUp,
    input wire       avs_read,
    input wire       avs_write,
    input wire       avs_waitrequest,
    input wire [2:0] switchOn,
    input wire       limitActive,
    input wire       driverEnable
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] prevOn_ff;
    // Edge detect on the switch pattern
    always @(posedge sys_clk)
        prevOn_ff <= switchOn;
    wire rise = |(switchOn & ~prevOn_ff);
    wire fall = |(prevOn_ff & ~switchOn);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    property p_rails;
        (railsUp != 3'h7)[*5] |-> switchOn == 3'h0 && !driverEnable;
    endproperty
    a_rails: assert property (p_rails) else $error("on without rails");
    property p_en;
        (switchOn != 3'h0) |-> driverEnable;
    endproperty
    a_en: assert property (p_en) else $error("switch on, driver off");
    property p_brk;
        fall |-> !rise;
    endproperty
    a_brk: assert property (p_brk) else $error("make with break");
    property p_gap;
        fall |=> !rise;
    endproperty
    a_gap: assert property (p_gap) else $error("no dead cycle");
    property p_dead;
        rise |-> $past(switchOn) == $past(switchOn, 2);
    endproperty
    a_dead: assert property (p_dead) else $error("make too soon");
    property p_off;
        (colourSel == 2'h3)[*8] |-> switchOn == 3'h0;
    endproperty
    a_off: assert property (p_off) else $error("off code lit");
    property p_wait;
        $rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("bad wait");
    property p_lim;
        $rose(limitActive) |-> switchOn != 3'h0;
    endproperty
    a_lim: assert property (p_lim) else $error("limit, no switch");
    c_make: cover property (rise);
    c_lim: cover property ($rose(limitActive));
    c_rd: cover property (avs_read && !avs_waitrequest);
endmodule // lsc_strobe_ctrl_asserts
bind lsc_strobe_ctrl lsc_strobe_ctrl_asserts u_chk (.sys_clk, .reset,
    .colourSel, .railsUp, .avs_read, .avs_write, .avs_waitrequest,
    .switchOn, .limitActive, .driverEnable);

// file: verif/led_strobe_current_control_tb.sv
// Self-checking bench for the strobe controller
module led_strobe_current_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic [1:0]  want = 2'h3;
    logic [2:0]  railsUp = 3'h0;
    logic [3:0]  addr = 4'h0;
    logic        rdEn = 1'b0;
    logic        wrEn = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] v;
    logic        waitReq;
    logic        limAct;
    logic        drvEn;
    logic [1:0]  colourSel;
    logic [2:0]  swOn;
    logic [9:0]  code;
    logic [3:0]  limLvl;
    int          failures = 0;
    int          check_count = 0;
    int          cyc = 0;
    lsc_colour_src src (.sys_clk(sys_clk), .want(want), .colourSel(colourSel));
    lsc_strobe_ctrl dut (.sys_clk(sys_clk), .reset(reset),
        .colourSel(colourSel), .railsUp(railsUp), .avs_address(addr),
        .avs_read(rdEn), .avs_write(wrEn), .avs_writedata(wdata),
        .avs_readdata(rdata), .avs_waitrequest(waitReq), .switchOn(swOn),
        .currentCode(code), .limitActive(limAct), .limitLevel(limLvl),
        .driverEnable(drvEn));
    // 250 MHz clock
    always #2 sys_clk = ~sys_clk;
    // Hang guard, well above the fewer than a thousand cycles needed
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            failures++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Held until the rising edge at which waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wrEn <= w;
        rdEn <= !w;
        do @(posedge sys_clk); while (waitReq !== 1'b0);
        v = rdata;
        rdEn <= 1'b0;
        wrEn <= 1'b0;
    endtask
    // Red then green with dead time d; counts dark and limited cycles
    task automatic gap(input logic [7:0] d, output int z, output int l);
        z = 0;
        l = 0;
        bus(1'b1, 4'h3, {24'h0, d});
        want <= 2'h0;
        idle(30);
        want <= 2'h1;
        repeat (40)
        begin
            @(posedge sys_clk);
            z += (swOn === 3'h0);
            l += (limAct === 1'b1);
        end
    endtask
    task automatic t_regs;
        logic [31:0] r[6] = '{32'h29, 32'h29, 32'h29, 32'h4, 32'h111, 32'h10};
        bus(1'b1, 4'hF, 32'h55);
        bus(1'b0, 4'hF, 32'h0);
        chk(v, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b0, 4'(i), 32'h0);
            chk(v, r[i]);
        end
        $display("regs done");
    endtask
    task automatic t_rails;
        want <= 2'h0;
        railsUp <= 3'h3;
        idle(20);
        chk({28'h0, drvEn, swOn}, 32'h0);
        railsUp <= 3'h7;
        idle(20);
        chk({28'h0, drvEn, swOn}, 32'h9);
        $display("rails done");
    endtask
    task automatic t_colours;
        logic [9:0] c[3] = '{10'h3FF, 10'h155, 10'h29};
        for (int i = 0; i < 3; i++)
            bus(1'b1, 4'(i), {22'h0, c[i]});
        for (int i = 0; i < 4; i++)
        begin
            want <= 2'(i);
            idle(30);
            chk({29'h0, swOn}, (i == 3) ? 32'h0 : 32'h1 << i);
            if (i < 3)
                chk({22'h0, code}, {22'h0, c[i]});
        end
        $display("colours done");
    endtask
    task automatic t_dead;
        int a;
        int b;
        int l;
        gap(8'h2, a, l);
        gap(8'hA, b, l);
        chk(32'(b - a), 32'h8);
        bus(1'b1, 4'h4, 32'h113);
        gap(8'hA, a, l);
        chk(32'(a), 32'h0);
        chk({29'h0, swOn}, 32'h2);
        bus(1'b1, 4'h4, 32'h111);
        $display("dead done");
    endtask
    task automatic t_limit;
        int z;
        int l;
        bus(1'b1, 4'h5, 32'h27);
        gap(8'h2, z, l);
        chk(32'(l != 0), 32'h1);
        chk({28'h0, limLvl}, 32'h7);
        bus(1'b1, 4'h5, 32'h47);
        gap(8'h2, z, l);
        chk(32'(l), 32'h0);
        bus(1'b1, 4'h5, 32'h17);
        $display("limit done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        idle(20);
        reset <= 1'b0;
        t_regs();
        t_rails();
        t_colours();
        t_dead();
        t_limit();
        report_and_stop();
    end
endmodule // led_strobe_current_control_tb
